// ### src/touch_report_params.svh
// Constants for the touch report formatter
`ifndef TOUCH_REPORT_PARAMS_SVH
`define TOUCH_REPORT_PARAMS_SVH
// Register byte addresses
`define REG_CTRL 12'h000
`define REG_TOUCH_ID 12'h004
`define REG_X 12'h008
`define REG_Y 12'h00C
`define REG_SIZE 12'h010
`define REG_STYLUS 12'h014
`define REG_PRESSURE 12'h018
`define REG_SEND 12'h01C
`define REG_STATUS 12'h020
`define REG_PENDING 12'h024
// Control register fields
`define CTRL_GEOM_BIT 0
`define CTRL_TOUCH_RID_LSB 8
`define CTRL_STYLUS_RID_LSB 16
`define CTRL_RESET 32'h0007_0101
// Send register codes
`define SEND_TOUCH 2'h1
`define SEND_STYLUS 2'h2
// Packet lengths in bytes
`define TOUCH_LEN 5'h12
`define STYLUS_LEN 5'h0B
// Timestamp base: 10 kHz from 25 MHz
`define CLK_HZ 25000000
`define STAMP_HZ 10000
`define STAMP_DIV (`CLK_HZ / `STAMP_HZ)
`define STAMP_DIV_W 12
`endif

// ### src/touch_report_pkg.sv
// Types for the touch report formatter
package touch_report_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } fmt_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } out_byte_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : touch_report_pkg

// ### src/touch_report_formatter.sv
// Touch and stylus report framer with APB registers and output FIFO
//------------------------------------------------------------
//------------------------------------------------------------

// Byte FIFO with parameterised width and depth
module report_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  // Pointer compare gives honest full and empty
  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  // Storage and pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) begin
        mem[wp[AW-1:0]] <= in_data;
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : report_fifo

module touch_report_formatter
  import touch_report_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic MESSAGE_PENDING_LINE_N
);
`include "touch_report_params.svh"

  typedef struct packed {
    fmt_state_t st;
    logic [31:0] ctrl;
    logic [7:0] touch_id;
    logic [7:0] touch_count;
    logic [15:0] x;
    logic [15:0] xc;
    logic [15:0] y;
    logic [15:0] yc;
    logic [7:0] width;
    logic [7:0] height;
    logic [7:0] stylus_flags;
    logic [7:0] pressure;
    logic [15:0] stamp;
    logic [`STAMP_DIV_W-1:0] div;
    logic [15:0] snap_stamp;
    logic is_stylus;
    logic [4:0] idx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    out_byte_t tx;
    logic tx_valid;
    logic pend_n;
  } state_t;

  state_t s;
  state_t next_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic fifo_push;
  logic [7:0] cur_byte;
  logic [4:0] cur_len;
  logic geom;
  logic access;
  logic tx_take;

  assign geom = s.ctrl[`CTRL_GEOM_BIT];
  assign access = PSEL && PENABLE && !s.pready;
  assign cur_len = s.is_stylus ? `STYLUS_LEN : `TOUCH_LEN;
  assign fifo_push = (s.st == ST_SEND);
  assign tx_take = s.tx_valid && TX_READY;

  // Byte selector for the packet under construction
  always_comb begin
    cur_byte = 8'h00;
    if (s.is_stylus) begin
      case (s.idx)
        5'h00: cur_byte = s.ctrl[`CTRL_STYLUS_RID_LSB +: 8];
        5'h01: cur_byte = {3'h0, s.stylus_flags[4], 1'b0, s.stylus_flags[2:0]};
        5'h02: cur_byte = s.x[7:0];
        5'h03: cur_byte = {4'h0, s.x[11:8]};
        5'h04: cur_byte = s.xc[7:0];
        5'h05: cur_byte = {4'h0, s.xc[11:8]};
        5'h06: cur_byte = s.y[7:0];
        5'h07: cur_byte = {4'h0, s.y[11:8]};
        5'h08: cur_byte = s.yc[7:0];
        5'h09: cur_byte = {4'h0, s.yc[11:8]};
        5'h0A: cur_byte = s.pressure;
        default: cur_byte = 8'h00;
      endcase
    end else begin
      case (s.idx)
        5'h00: cur_byte = s.ctrl[`CTRL_TOUCH_RID_LSB +: 8];
        5'h01: cur_byte = 8'h01;
        5'h02: cur_byte = s.touch_id;
        5'h03: cur_byte = s.x[7:0];
        5'h04: cur_byte = {4'h0, s.x[11:8]};
        5'h05: cur_byte = geom ? s.xc[7:0] : 8'h00;
        5'h06: cur_byte = geom ? {4'h0, s.xc[11:8]} : 8'h00;
        5'h07: cur_byte = s.y[7:0];
        5'h08: cur_byte = {4'h0, s.y[11:8]};
        5'h09: cur_byte = geom ? s.yc[7:0] : 8'h00;
        5'h0A: cur_byte = geom ? {4'h0, s.yc[11:8]} : 8'h00;
        5'h0B: cur_byte = geom ? s.width : 8'h00;
        5'h0D: cur_byte = geom ? s.height : 8'h00;
        5'h0F: cur_byte = s.snap_stamp[7:0];
        5'h10: cur_byte = s.snap_stamp[15:8];
        5'h11: cur_byte = s.touch_count;
        default: cur_byte = 8'h00;
      endcase
    end
  end

  // Next-state logic for registers, framer and output stage
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    // 10 kHz timestamp
    if (s.div == `STAMP_DIV_W'(`STAMP_DIV - 1)) begin
      next_s.div = '0;
      next_s.stamp = s.stamp + 16'h0001;
    end else begin
      next_s.div = s.div + 1'b1;
    end
    // Framer walks one byte per cycle, stalls on FIFO full
    if (s.st == ST_SEND && fifo_in_ready) begin
      if (s.idx == cur_len - 5'h01) begin
        next_s.st = ST_IDLE;
        next_s.idx = '0;
      end else begin
        next_s.idx = s.idx + 5'h01;
      end
    end
    // APB slave, one wait state
    if (access) begin
      next_s.pready = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0;
      if (PWRITE) begin
        case (PADDR)
          `REG_CTRL: next_s.ctrl = PWDATA;
          `REG_TOUCH_ID: begin
            next_s.touch_id = PWDATA[7:0];
            next_s.touch_count = PWDATA[15:8];
          end
          `REG_X: begin
            next_s.x = {4'h0, PWDATA[11:0]};
            next_s.xc = {4'h0, PWDATA[27:16]};
          end
          `REG_Y: begin
            next_s.y = {4'h0, PWDATA[11:0]};
            next_s.yc = {4'h0, PWDATA[27:16]};
          end
          `REG_SIZE: begin
            next_s.width = PWDATA[7:0];
            next_s.height = PWDATA[15:8];
          end
          `REG_STYLUS: next_s.stylus_flags = PWDATA[7:0];
          `REG_PRESSURE: next_s.pressure = PWDATA[7:0];
          `REG_SEND: begin
            if (s.st == ST_IDLE && (PWDATA[1:0] == `SEND_TOUCH ||
                PWDATA[1:0] == `SEND_STYLUS)) begin
              next_s.st = ST_SEND;
              next_s.idx = '0;
              next_s.is_stylus = (PWDATA[1:0] == `SEND_STYLUS);
              next_s.snap_stamp = s.stamp;
            end else begin
              next_s.pslverr = 1'b1;
            end
          end
          `REG_STATUS: next_s.pslverr = 1'b0;
          `REG_PENDING: next_s.pslverr = 1'b0;
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        case (PADDR)
          `REG_CTRL: next_s.prdata = s.ctrl;
          `REG_TOUCH_ID: next_s.prdata = {16'h0, s.touch_count, s.touch_id};
          `REG_X: next_s.prdata = {s.xc, s.x};
          `REG_Y: next_s.prdata = {s.yc, s.y};
          `REG_SIZE: next_s.prdata = {16'h0, s.height, s.width};
          `REG_STYLUS: next_s.prdata = {24'h0, s.stylus_flags};
          `REG_PRESSURE: next_s.prdata = {24'h0, s.pressure};
          `REG_SEND: next_s.prdata = 32'h0;
          `REG_STATUS: next_s.prdata = {s.stamp, 13'h0, !fifo_in_ready,
                                        fifo_out_valid, s.st == ST_SEND};
          `REG_PENDING: next_s.prdata = {31'h0, !s.pend_n};
          default: next_s.prdata = 32'h0;
        endcase
        next_s.pslverr = !(PADDR inside {`REG_CTRL, `REG_TOUCH_ID, `REG_X, `REG_Y,
                           `REG_SIZE, `REG_STYLUS, `REG_PRESSURE, `REG_SEND,
                           `REG_STATUS, `REG_PENDING});
      end
    end
    // Output register fed from the FIFO
    if (!s.tx_valid || TX_READY) begin
      next_s.tx_valid = fifo_out_valid;
      next_s.tx = {fifo_out_data[8:1], fifo_out_data[0]};
    end
    // Pending while any byte waits in the framer, FIFO or output
    next_s.pend_n = !(next_s.st == ST_SEND || fifo_out_valid || next_s.tx_valid);
  end

  report_fifo #(.W(9), .D(16)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({cur_byte, s.idx == cur_len - 5'h01}),
    .out_valid(fifo_out_valid),
    .out_ready(!s.tx_valid || TX_READY),
    .out_data(fifo_out_data)
  );

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.pend_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign TX_DATA = s.tx.data;
  assign TX_LAST = s.tx.last;
  assign TX_VALID = s.tx_valid;
  assign MESSAGE_PENDING_LINE_N = s.pend_n;

  // Checks
  pos_nibble_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && !s.is_stylus && (s.idx == 5'h04 || s.idx == 5'h08))
    |-> cur_byte[7:4] == 4'h0) else $error("position high nibble set");
  geom_off_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && !s.is_stylus && !geom && s.idx inside {[5'h05:5'h0E]}
    && s.idx != 5'h07 && s.idx != 5'h08) |-> cur_byte == 8'h00)
    else $error("reserved byte not zero");
  touch_len_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && !s.is_stylus) |-> s.idx <= 5'h11)
    else $error("touch packet too long");
  stylus_rsv_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && s.is_stylus && s.idx == 5'h01) |-> cur_byte[7:5] == 3'h0
    && !cur_byte[3]) else $error("stylus reserved bit set");
  pend_line_a: assert property (@(posedge CLK) disable iff (RST)
    s.tx_valid |-> !MESSAGE_PENDING_LINE_N) else $error("pending line high");
  apb_ready_a: assert property (@(posedge CLK) disable iff (RST)
    (PSEL && PENABLE && !PREADY) |=> PREADY) else $error("no ready");
  stamp_step_a: assert property (@(posedge CLK) disable iff (RST)
    (s.div != `STAMP_DIV_W'(`STAMP_DIV - 1)) |=> $stable(s.stamp))
    else $error("stamp moved early");
  tid_byte_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && !s.is_stylus && s.idx == 5'h02) |-> cur_byte == s.touch_id)
    else $error("touch id byte wrong");
  // A stalled byte must not change under the host
  tx_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (TX_VALID && !TX_READY) |=> (TX_VALID && $stable(TX_DATA) && $stable(TX_LAST)))
    else $error("byte changed while stalled");
  stylus_len_a: assert property (@(posedge CLK) disable iff (RST)
    (s.st == ST_SEND && s.is_stylus) |-> s.idx <= 5'h0A)
    else $error("stylus packet too long");
  send_touch_c: cover property (@(posedge CLK) s.st == ST_SEND && !s.is_stylus);
  send_stylus_c: cover property (@(posedge CLK) s.st == ST_SEND && s.is_stylus);
  fifo_full_c: cover property (@(posedge CLK) !fifo_in_ready);
endmodule : touch_report_formatter

// ### tb/host_rx_model.sv
// Host side receiver model for the report byte stream
module host_rx_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic stall,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board strap: interface select held low so reports flow
  localparam logic interface_select_pin = 1'b0;
  logic [8:0] rx_q[$];
  logic phase;
  // Ready is dropped while stalled, and every other cycle in slow mode
  always @(posedge clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      tx_ready <= !stall && (!slow || phase) && !interface_select_pin;
      if (tx_valid && tx_ready) begin
        rx_q.push_back({tx_last, tx_data});
      end
    end
  end
endmodule : host_rx_model

// ### tb/tb.sv
// Testbench for the touch report formatter
`include "touch_report_params.svh"
module tb;
  import touch_report_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic geom;
    logic [7:0] rid, id, cnt;
    logic [11:0] x, xc, y, yc;
    logic [7:0] w, h;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tx_last, tx_valid, tx_ready, pend_n;
  logic [7:0] tx_data;
  logic stall = 1'b0, slow = 1'b0;
  logic [8:0] pkt[0:17];
  logic [7:0] e[0:17];
  logic [15:0] s;
  int fails = 0, checks = 0, cycles = 0, k;
  row_t rows[3] = '{
    '{1'b1, 8'h01, 8'h00, 8'h03, 12'hABC, 12'h123, 12'h456, 12'h789, 8'h11, 8'h22},
    '{1'b0, 8'h01, 8'hFF, 8'h01, 12'hFFF, 12'hEEE, 12'h001, 12'hDDD, 8'h33, 8'h44},
    '{1'b1, 8'h2A, 8'h07, 8'h10, 12'h000, 12'hFFF, 12'h800, 12'h001, 8'hFF, 8'h80}};
  // ------------------------------------------------------------
  // Design and host model
  // ------------------------------------------------------------
  touch_report_formatter u_touch_report_formatter (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .MESSAGE_PENDING_LINE_N(pend_n));
  host_rx_model u_host_rx_model (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall), .slow(slow));
  // ------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic get_pkt(input int n);
    while (u_host_rx_model.rx_q.size() < n) @(posedge clk);
    for (int i = 0; i < n; i++) pkt[i] = u_host_rx_model.rx_q.pop_front();
  endtask : get_pkt
  // Sends one touch and compares all bytes; stamp bytes only when asked
  task automatic touch(input row_t r, input logic [15:0] st, input logic cs);
    logic g;
    g = r.geom;
    apb(1'b1, `REG_CTRL, {8'h00, 8'h07, r.rid, 7'h00, g});
    apb(1'b1, `REG_TOUCH_ID, {16'hFFFF, r.cnt, r.id});
    apb(1'b1, `REG_X, {4'hF, r.xc, 4'hF, r.x});
    apb(1'b1, `REG_Y, {4'hF, r.yc, 4'hF, r.y});
    apb(1'b1, `REG_SIZE, {16'h0, r.h, r.w});
    apb(1'b1, `REG_SEND, 32'h1);
    check(err, 1'b0);
    get_pkt(18);
    e = '{r.rid, 8'h01, r.id, r.x[7:0], {4'h0, r.x[11:8]}, g ? r.xc[7:0] : 8'h00,
      g ? {4'h0, r.xc[11:8]} : 8'h00, r.y[7:0], {4'h0, r.y[11:8]}, g ? r.yc[7:0] : 8'h00,
      g ? {4'h0, r.yc[11:8]} : 8'h00, g ? r.w : 8'h00, 8'h00, g ? r.h : 8'h00, 8'h00,
      st[7:0], st[15:8], r.cnt};
    for (int i = 0; i < 18; i++) begin
      if (cs || i < 15 || i > 16) check(pkt[i], {i == 17, e[i]});
    end
  endtask : touch
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    check({pend_n, tx_valid, pready}, 3'b100);
    rst <= 1'b0;
    apb(1'b0, `REG_CTRL, 32'h0);
    check(rd, `CTRL_RESET);
    apb(1'b0, 12'h030, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Ordinary touch cases, alternating a prompt and a slow host
    for (int n = 0; n < 3; n++) begin
      slow <= n[0];
      touch(rows[n], 16'h0, 1'b0);
    end
    // Stylus flags, bits 0 to 4 each alone, then all bits with reserved ones set
    foreach (e[f]) if (f < 6) begin
      s[7:0] = (f == 5) ? 8'hFF : (f == 4) ? 8'h10 : (8'h01 << f);
      apb(1'b1, `REG_STYLUS, {24'h0, s[7:0]});
      apb(1'b1, `REG_X, 32'hF321_F654);
      apb(1'b1, `REG_Y, 32'hF0AB_FCDE);
      apb(1'b1, `REG_PRESSURE, {24'h0, s[7:0] ^ 8'h5A});
      apb(1'b1, `REG_SEND, 32'h2);
      get_pkt(11);
      e = '{8'h07, s[7:0] & 8'h17, 8'h54, 8'h06, 8'h21, 8'h03, 8'hDE, 8'h0C, 8'hAB, 8'h00,
        s[7:0] ^ 8'h5A, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
      for (int i = 0; i < 11; i++) check(pkt[i], {i == 10, e[i]});
    end
    // Stamp steps once per 2500 cycles and is captured at send
    slow <= 1'b0;
    apb(1'b0, `REG_STATUS, 32'h0);
    s = rd[31:16];
    for (k = 0; k < 1000 && rd[31:16] === s; k++) apb(1'b0, `REG_STATUS, 32'h0);
    s = rd[31:16];
    repeat (2500) @(posedge clk);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[31:16], s + 16'h1);
    touch(rows[0], s + 16'h1, 1'b1);
    // Stalled host: FIFO fills, pending line low, sends while busy refused
    stall <= 1'b1;
    apb(1'b1, `REG_SEND, 32'h1);
    for (k = 0; k < 20 && rd[2] !== 1'b1; k++) apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[2:0], 3'h7);
    check(pend_n, 1'b0);
    apb(1'b0, `REG_PENDING, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, `REG_SEND, 32'h2);
    check(err, 1'b1);
    apb(1'b1, `REG_SEND, 32'h3);
    check(err, 1'b1);
    stall <= 1'b0;
    get_pkt(18);
    check(pkt[17], {1'b1, rows[0].cnt});
    repeat (4) @(posedge clk);
    check({pend_n, u_host_rx_model.rx_q.size() == 0}, 2'b11);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[2:0], 3'h0);
    // A bad send code while idle is refused and starts nothing
    apb(1'b1, `REG_SEND, 32'h3);
    check(err, 1'b1);
    apb(1'b0, `REG_PENDING, 32'h0);
    check(rd, 32'h0);
    // Reset in mid-run restores the control defaults over other values
    apb(1'b1, `REG_CTRL, 32'h0000_2A00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({pend_n, tx_valid, pready}, 3'b100);
    rst <= 1'b0;
    apb(1'b0, `REG_CTRL, 32'h0);
    check(rd, `CTRL_RESET);
    end_of_test();
  end
endmodule : tb
